// [rtl/acwzd_params.svh]
/*
 constants for the config word zero decoder: field positions, reset values, codes.
 assumes inclusion by bare name from the package and the design file.
*/
`ifndef ACWZD_PARAMS_SVH
`define ACWZD_PARAMS_SVH
`define ACWZD_WORD_W        10
`define ACWZD_BUS_W         12
`define ACWZD_RESET_VAL     10'h020
`define ACWZD_SEL_WORD0     2'h0
`define ACWZD_BIT_REF       0
`define ACWZD_BIT_MODE      1
`define ACWZD_BIT_SLEEP     2
`define ACWZD_PICK_LO       3
`define ACWZD_PAIR_LO       5
`define ACWZD_BIT_SCAN      7
`define ACWZD_CHECK_LO      8
`define ACWZD_CNT_W         5
`define ACWZD_DATA_W        12
`endif

// [rtl/acwzd_pkg.sv]
/*
 types for the config word zero decoder.
 assumes the params header sits beside it.
*/
`include "acwzd_params.svh"
`default_nettype none
package acwzd_pkg;
	typedef enum logic [1:0] {
		ACWZD_CHK_NORMAL = 2'h0,
		ACWZD_CHK_UPPER  = 2'h1,
		ACWZD_CHK_MID    = 2'h2,
		ACWZD_CHK_LOWER  = 2'h3
	} acwzd_check_type;
	typedef enum logic [2:0] {
		ACWZD_ST_IDLE = 3'h1,
		ACWZD_ST_HOLD = 3'h2,
		ACWZD_ST_CONV = 3'h4
	} acwzd_state_type;
endpackage
`default_nettype wire

// [rtl/acwzd_top.sv]
/*
 decoder of configuration word zero plus conversion sequencing and ready flag.
 assumes host bus strobes and sample clock are async pins; conversion data
 is supplied by the analog core on the system clock.
*/
// What this block does
// - bit 0 selects internal or external reference
// - continuous mode: sample per falling clock edge
// - single mode: each pulse launches one sequence
// - single mode: falling edge holds all inputs, then converts
// - ready flag only once trigger met
// - bit 2 powers down, resets zero
// - config access still works while asleep
// - fifo reads still work while asleep
// - bits 3,4 channel pick, reset zero
// - bits 5,6 pair count, reset 1,0
// - bit 7 autoscan enable, reset zero
// - bits 8,9 test voltage select, reset zero
// - test mode keeps ready flag off
// - D0-D9 value, D10-D11 word select
// - trigger when fifo got trigger-level values
// - test code 00 normal,01 upper,10 mid,11 lower
`include "acwzd_params.svh"
`default_nettype none
module acwzd_top
	import acwzd_pkg::*;
(
	input  wire logic                      clk_sys,
	input  wire logic                      reset_n,
	input  wire logic                      write_strobe_n,
	input  wire logic [`ACWZD_BUS_W-1:0]   bus_data_in,
	input  wire logic                      sample_clock_in,
	input  wire logic [3:0]                trigger_level,
	input  wire logic                      fifo_read,
	output logic [`ACWZD_WORD_W-1:0]       converter_setup_word_zero,
	output logic                           ext_reference_sel,
	output logic                           sleep_ctl,
	output logic                           channel_hold,
	output logic                           convert_busy,
	output logic [1:0]                     check_voltage_sel,
	output logic                           fifo_write,
	output logic                           samples_ready_flag
);
	logic [1:0]                     rst_sync_r;
	logic                           rst_n_i;
	logic [2:0]                     wr_sync_r;
	logic [`ACWZD_BUS_W-1:0]        bus_s1_r;
	logic [`ACWZD_BUS_W-1:0]        bus_s2_r;
	logic [2:0]                     clk_sync_r;
	logic [`ACWZD_WORD_W-1:0]       word_r;
	logic [`ACWZD_WORD_W-1:0]       word_nxt;
	acwzd_state_type                state_r;
	acwzd_state_type                state_nxt;
	logic [1:0]                     seq_cnt_r;
	logic [1:0]                     seq_cnt_nxt;
	logic [`ACWZD_CNT_W-1:0]        fill_r;
	logic [`ACWZD_CNT_W-1:0]        fill_nxt;
	logic                           fwr_r;
	logic                           fwr_nxt;
	logic                           ready_r;
	logic                           ready_nxt;

	wire logic write_edge;
	wire logic word0_hit;
	wire logic sample_fall;
	wire logic single_mode;
	wire logic asleep;
	wire logic test_on;
	wire logic [1:0] seq_len;
	wire logic trig_met;

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) rst_sync_r <= 2'h0;
		else rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n_i = rst_sync_r[1];

	// pin synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge clk_sys or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_sync_r  <= 3'h7;
			clk_sync_r <= 3'h0;
			bus_s1_r   <= 12'h000;
			bus_s2_r   <= 12'h000;
		end else begin
			wr_sync_r  <= {wr_sync_r[1:0], write_strobe_n};
			clk_sync_r <= {clk_sync_r[1:0], sample_clock_in};
			bus_s1_r   <= bus_data_in;
			bus_s2_r   <= bus_s1_r;
		end
	end

	// rising edge of write strobe latches the word; decode runs while asleep too
	assign write_edge  = wr_sync_r[1] & ~wr_sync_r[2];
	assign word0_hit   = write_edge &
		(bus_s2_r[`ACWZD_BUS_W-1:`ACWZD_WORD_W] == `ACWZD_SEL_WORD0);
	assign word_nxt    = word0_hit ? bus_s2_r[`ACWZD_WORD_W-1:0] : word_r;

	assign single_mode = word_r[`ACWZD_BIT_MODE];
	assign asleep      = word_r[`ACWZD_BIT_SLEEP];
	assign test_on     = (check_voltage_sel != ACWZD_CHK_NORMAL);
	assign sample_fall = ~clk_sync_r[1] & clk_sync_r[2];

	// index of the last sample in a sequence (sample count minus one) from scan and pick fields
	assign seq_len = word_r[`ACWZD_BIT_SCAN] ?
		word_r[`ACWZD_PICK_LO +: 2] : 2'h0;

	// sequencer: in single mode hold all inputs on falling edge then convert in turn; continuous mode writes directly
	always_comb begin
		state_nxt   = state_r;
		seq_cnt_nxt = seq_cnt_r;
		fwr_nxt     = 1'b0;
		case (state_r)
			ACWZD_ST_IDLE: begin
				if (sample_fall && !asleep) begin
					if (single_mode) begin
						state_nxt   = ACWZD_ST_HOLD;
						seq_cnt_nxt = 2'h0;
					end else begin
						fwr_nxt = 1'b1;
					end
				end
			end
			ACWZD_ST_HOLD: begin
				state_nxt = ACWZD_ST_CONV;
			end
			ACWZD_ST_CONV: begin
				fwr_nxt = 1'b1;
				if (seq_cnt_r == seq_len) state_nxt = ACWZD_ST_IDLE;
				else seq_cnt_nxt = seq_cnt_r + 2'h1;
			end
			default: begin
				state_nxt = ACWZD_ST_IDLE;
			end
		endcase
	end

	// count new values since last trigger; reads stay legal while asleep
	assign trig_met = (fill_r >= {1'b0, trigger_level}) && (trigger_level != 4'h0);
	always_comb begin
		fill_nxt  = fill_r;
		ready_nxt = 1'b0;
		if (trig_met) begin
			fill_nxt  = fill_r - {1'b0, trigger_level};
			ready_nxt = ~test_on;
		end
		if (fwr_r) fill_nxt = fill_nxt + 5'h01;
		if (fifo_read && asleep) fill_nxt = fill_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_n_i) begin
		if (!rst_n_i) begin
			word_r    <= `ACWZD_RESET_VAL;
			state_r   <= ACWZD_ST_IDLE;
			seq_cnt_r <= 2'h0;
			fill_r    <= 5'h00;
			fwr_r     <= 1'b0;
			ready_r   <= 1'b0;
		end else begin
			word_r    <= word_nxt;
			state_r   <= state_nxt;
			seq_cnt_r <= seq_cnt_nxt;
			fill_r    <= fill_nxt;
			fwr_r     <= fwr_nxt;
			ready_r   <= ready_nxt;
		end
	end

	// registered outputs
	always_ff @(posedge clk_sys or negedge rst_n_i) begin
		if (!rst_n_i) begin
			converter_setup_word_zero <= `ACWZD_RESET_VAL;
			ext_reference_sel         <= 1'b0;
			sleep_ctl                 <= 1'b0;
			channel_hold              <= 1'b0;
			convert_busy              <= 1'b0;
			check_voltage_sel         <= 2'h0;
			fifo_write                <= 1'b0;
			samples_ready_flag        <= 1'b0;
		end else begin
			converter_setup_word_zero <= word_nxt;
			ext_reference_sel         <= word_nxt[`ACWZD_BIT_REF];
			sleep_ctl                 <= word_nxt[`ACWZD_BIT_SLEEP];
			channel_hold              <= (state_nxt != ACWZD_ST_IDLE);
			convert_busy              <= (state_nxt == ACWZD_ST_CONV);
			check_voltage_sel         <= word_nxt[`ACWZD_CHECK_LO +: 2];
			fifo_write                <= fwr_nxt;
			samples_ready_flag        <= ready_nxt;
		end
	end
endmodule
`default_nettype wire

// [sim/acwzd_assertions.sv]
/* checker bound to acwzd_top. sees only the ports of that module. */
`default_nettype none
module acwzd_assertions(
	input wire logic        clk_sys, reset_n, write_strobe_n, sample_clock_in, fifo_read,
	input wire logic        ext_reference_sel, sleep_ctl, channel_hold, convert_busy,
	input wire logic        fifo_write, samples_ready_flag,
	input wire logic [11:0] bus_data_in,
	input wire logic [9:0]  converter_setup_word_zero,
	input wire logic [3:0]  trigger_level,
	input wire logic [1:0]  check_voltage_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [9:0] w = converter_setup_word_zero;
	logic            prev_n = 1'b1;
	logic [3:0]      age_r = 4'hf;
	always_ff @(posedge clk_sys) begin
		prev_n <= write_strobe_n;
		age_r <= (write_strobe_n && !prev_n) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence hold_start;
		$rose(channel_hold);
	endsequence
	sequence one_write;
		fifo_write && !(w[1] && w[7]);
	endsequence
	ref_bit_a: assert property (ext_reference_sel == w[0]) else $error("ref bit");
	check_sel_a: assert property (check_voltage_sel == w[9:8]) else $error("check");
	test_quiet_a: assert property (check_voltage_sel != 2'h0 |-> !samples_ready_flag)
		else $error("flag in test");
	word_load_a: assert property ($changed(w) |-> age_r inside {[4'h1:4'h8]})
		else $error("word change");
	hold_seq_a: assert property (hold_start |=> convert_busy ##1 fifo_write)
		else $error("hold order");
	lone_write_a: assert property (one_write |=> !fifo_write) else $error("write");
	flag_cause_a: assert property (samples_ready_flag |-> $past(fifo_write, 2))
		else $error("flag cause");
	no_wake_a: assert property ($rose(channel_hold) |-> !$past(sleep_ctl)) else $error("wake");
endmodule
bind acwzd_top acwzd_assertions chk (.*);
`default_nettype wire

// [sim/acwzd_host.sv]
/* host processor model on bus and sample pin. assumes the shared clk_sys. */
`default_nettype none
module acwzd_host(
	input wire logic    clk_sys,
	output logic        write_strobe_n = 1'b1,
	output logic [11:0] bus_data_in = 12'h000,
	output logic        sample_clock_in = 1'b1,
	output logic        fifo_read = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic wr(input logic [1:0] sel, input logic [9:0] v);
		@(posedge clk_sys);
		#1 bus_data_in = {sel, v};
		write_strobe_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 write_strobe_n = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1 bus_data_in = ~bus_data_in;
	endtask
	task automatic edges(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1 sample_clock_in = 1'b0;
			repeat (4) @(posedge clk_sys);
			#1 sample_clock_in = 1'b1;
			repeat (8) @(posedge clk_sys);
			#1;
		end
	endtask
	task automatic rd();
		@(posedge clk_sys);
		#1 fifo_read = 1'b1;
		@(posedge clk_sys);
		#1 fifo_read = 1'b0;
	endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
/* self-checking bench for acwzd_top. assumes acwzd_host drives the pins. */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys = 1'b0;
	logic       reset_n = 1'b0;
	logic [3:0] trigger_level = 4'h2;
	wire logic  write_strobe_n, sample_clock_in, fifo_read, ext_reference_sel, sleep_ctl;
	wire logic  channel_hold, convert_busy, fifo_write, samples_ready_flag;
	wire logic [11:0] bus_data_in;
	wire logic [9:0]  converter_setup_word_zero;
	wire logic [1:0]  check_voltage_sel;
	int         err_total = 0, n_compared = 0, n_wr = 0, n_flag = 0, w0, f0;
	acwzd_top DUT (.*);
	acwzd_host host (.*);
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		n_wr += int'(fifo_write === 1'b1);
		n_flag += int'(samples_ready_flag === 1'b1);
	end
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (err_total == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic t_fields();
		logic [9:0] v;
		chk(converter_setup_word_zero, 10'h020);
		for (int i = 0; i < 4; i++) begin
			v = {i[1:0], i[0] ? 8'hab : 8'h54};
			host.wr(2'h0, v);
			chk(converter_setup_word_zero, v);
			chk({ext_reference_sel, sleep_ctl, check_voltage_sel}, {v[0], v[2], v[9:8]});
		end
		for (int s = 1; s < 4; s++) begin
			host.wr(s[1:0], 10'h0f0);
			chk(converter_setup_word_zero, v);
		end
	endtask
	task automatic t_cont();
		host.wr(2'h0, 10'h000);
		w0 = n_wr;
		f0 = n_flag;
		host.edges(4);
		chk(10'(n_wr - w0), 10'h004);
		chk(10'(n_flag - f0), 10'h002);
	endtask
	task automatic t_sleep();
		host.wr(2'h0, 10'h004);
		w0 = n_wr;
		host.edges(2);
		host.rd();
		chk(10'(n_wr - w0), 10'h000);
		host.wr(2'h0, 10'h006);
		chk(converter_setup_word_zero, 10'h006);
	endtask
	task automatic t_single();
		host.wr(2'h0, 10'h002);
		w0 = n_wr;
		f0 = n_flag;
		host.edges(2);
		chk(10'(n_wr - w0), 10'h002);
		host.wr(2'h0, 10'h09a);
		host.edges(1);
		chk(10'(n_wr - w0), 10'h006);
		chk(10'(n_flag - f0), 10'h003);
	endtask
	task automatic t_test();
		trigger_level = 4'h1;
		host.wr(2'h0, 10'h100);
		w0 = n_wr;
		f0 = n_flag;
		host.edges(4);
		host.rd();
		chk(10'(n_wr - w0), 10'h004);
		chk(10'(n_flag - f0), 10'h000);
		host.wr(2'h0, 10'h000);
		host.edges(2);
		chk(10'(n_flag - f0), 10'h002);
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		t_fields();
		t_cont();
		t_sleep();
		t_single();
		t_test();
		results();
	end
	initial begin
		#200000;
		err_total++;
		results();
	end
endmodule
`default_nettype wire
